// File: aobc_consts.vh
// constants for the analog output buffer and clocking block
`ifndef AOBC_CONSTS_VH
`define AOBC_CONSTS_VH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define AOBC_CLK_HZ 25'd10000000
`define AOBC_RATE_W 24
`define AOBC_RATE_DEF 24'd300000

// ----------------------------------------------------------------
// buffer geometry
// ----------------------------------------------------------------
`define AOBC_DW 16
`define AOBC_AW 8
`define AOBC_DEPTH 9'd256
`define AOBC_SIGN_FLIP 16'h8000

// ----------------------------------------------------------------
// register map (word index on reg_addr)
// ----------------------------------------------------------------
`define AOBC_OFS_CTRL 2'h0
`define AOBC_OFS_BOPS 2'h1
`define AOBC_OFS_RATE 2'h2
`define AOBC_OFS_DATA 2'h3

// ----------------------------------------------------------------
// channel_control_reg fields
// ----------------------------------------------------------------
`define AOBC_CTRL_SIZE_LO 1
`define AOBC_CTRL_SIZE_HI 3
`define AOBC_CTRL_TWOS 4
`define AOBC_CTRL_INT_LO 8
`define AOBC_CTRL_INT_HI 10
`define AOBC_CTRL_FLAG 11
`define AOBC_INT_IDLE 3'h0
`define AOBC_INT_EMPTY 3'h2
`define AOBC_INT_LOQ 3'h3

// ----------------------------------------------------------------
// buffer operations register fields
// ----------------------------------------------------------------
`define AOBC_BOPS_EXT 4
`define AOBC_BOPS_EN 5
`define AOBC_BOPS_CLR 6
`define AOBC_BOPS_EMPTY 12
`define AOBC_BOPS_LOQ 13
`define AOBC_BOPS_FULL 14
`define AOBC_BOPS_LVL_LO 16
`define AOBC_BOPS_LVL_HI 24

`endif

// File: aobc_fifo.v
// sample buffer of one output channel with selectable active size
`timescale 1ns/1ns
`default_nettype none
`include "aobc_consts.vh"

module aobc_fifo (
   input wire clk_sys,
   input wire nrst,
   input wire clr,
   input wire wr_en,
   input wire [15:0] wr_data,
   input wire rd_en,
   input wire [8:0] cap,
   output wire [15:0] rd_data,
   output wire [8:0] level,
   output wire empty,
   output wire full
);
   reg [15:0] mem [0:255];
   reg [7:0] wr_ptr;
   reg [7:0] rd_ptr;
   reg [8:0] count;
   wire do_wr;
   wire do_rd;

   // ----------------------------------------------------------------
   // flags; full follows the active size, not the array size
   // ----------------------------------------------------------------
   assign empty = (count == 9'h000);
   assign full = (count >= cap);
   assign level = count;
   assign rd_data = mem[rd_ptr];
   assign do_wr = wr_en & ~full;  // refused, never overwritten
   assign do_rd = rd_en & ~empty;

   // storage array, no reset needed on the data itself
   always @(posedge clk_sys) begin
      if (do_wr) begin
         mem[wr_ptr] <= wr_data;
      end
   end

   // pointers and fill count
   always @(posedge clk_sys) begin
      if (!nrst || clr) begin
         wr_ptr <= 8'h00;
         rd_ptr <= 8'h00;
         count <= 9'h000;
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 8'h01;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 8'h01;
         end
         if (do_wr && !do_rd) begin
            count <= count + 9'h001;
         end else if (do_rd && !do_wr) begin
            count <= count - 9'h001;
         end
      end
   end
endmodule // aobc_fifo

`default_nettype wire

// File: aobc_rategen.v
// fractional rate generator giving one-cycle sample ticks
`timescale 1ns/1ns
`default_nettype none
`include "aobc_consts.vh"

module aobc_rategen (
   input wire clk_sys,
   input wire nrst,
   input wire run,
   input wire [23:0] rate,
   output reg tick
);
   reg [23:0] acc;
   wire [24:0] eff;
   wire [24:0] sum;
   wire [24:0] wrap;

   // ----------------------------------------------------------------
   // phase accumulator: average rate is exact even when the clock
   // is no whole multiple; jitter is one clk_sys period
   // ----------------------------------------------------------------
   assign eff = ({1'b0, rate} > `AOBC_CLK_HZ) ? `AOBC_CLK_HZ :
                {1'b0, rate};
   assign sum = {1'b0, acc} + eff;
   // only taken once sum has passed the clock, so it fits in 24 bits
   assign wrap = sum - `AOBC_CLK_HZ;

   always @(posedge clk_sys) begin
      if (!nrst || !run) begin
         acc <= 24'h000000;
         tick <= 1'b0;
      end else if (sum >= `AOBC_CLK_HZ) begin
         acc <= wrap[23:0];
         tick <= 1'b1;
      end else begin
         acc <= sum[23:0];
         tick <= 1'b0;
      end
   end
endmodule // aobc_rategen

`default_nettype wire

// File: aobc_top.v
// two-channel analog output buffer and sample clock control
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "aobc_consts.vh"

module aobc_top (
   input wire clk_sys,
   input wire nrst,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire ext_clk_a,
   input wire ext_clk_b,
   output wire [15:0] dac_data_a,
   output wire [15:0] dac_data_b,
   output wire dac_load_a,
   output wire dac_load_b,
   output wire irq_req
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // active buffer size from a 3-bit size code, 0 is the maximum
   function [8:0] aobc_cap;
      input [2:0] code;
      begin
         aobc_cap = `AOBC_DEPTH >> code;
      end
   endfunction

   // offset binary passes, two's complement has its sign flipped
   function [15:0] aobc_code;
      input [15:0] d;
      input twos;
      begin
         aobc_code = twos ? (d ^ `AOBC_SIGN_FLIP) : d;
      end
   endfunction

   // ----------------------------------------------------------------
   // per-channel readback and outputs, packed by channel
   // ----------------------------------------------------------------
   wire [63:0] ctrl_rb;
   wire [63:0] bops_rb;
   wire [63:0] rate_rb;
   wire [31:0] dac_all;
   wire [1:0] load_all;
   wire [1:0] flag_all;
   wire [1:0] ext_all;
   wire bus_ok;

   assign ext_all = {ext_clk_b, ext_clk_a};
   assign bus_ok = (reg_addr[3] == 1'b0); // upper half is unmapped

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : ch
         reg [2:0] int_sel;
         reg flag;
         reg twos;
         reg [2:0] size_code;
         reg ext_sel;
         reg clk_en;
         reg [23:0] rate;
         reg [15:0] dac;
         reg load;
         reg ext_prev;
         reg cond_prev;
         reg [2:0] sel_prev;
         wire hit;
         wire wr_ctrl;
         wire wr_bops;
         wire wr_rate;
         wire wr_data;
         wire int_tick;
         wire ext_edge;
         wire tick;
         wire [15:0] head;
         wire [8:0] level;
         wire [8:0] cap;
         wire empty;
         wire full;
         wire low_q;
         wire pop;
         reg cond;
         wire raise;
         wire next_flag;

         // ----------------------------------------------------------
         // address decode for this channel
         // ----------------------------------------------------------
         assign hit = bus_ok && (reg_addr[2] == (c == 1));
         assign wr_ctrl = reg_wr && hit &&
                          (reg_addr[1:0] == `AOBC_OFS_CTRL);
         assign wr_bops = reg_wr && hit &&
                          (reg_addr[1:0] == `AOBC_OFS_BOPS);
         assign wr_rate = reg_wr && hit &&
                          (reg_addr[1:0] == `AOBC_OFS_RATE);
         assign wr_data = reg_wr && hit &&
                          (reg_addr[1:0] == `AOBC_OFS_DATA);

         // control and buffer-operation settings
         always @(posedge clk_sys) begin
            if (!nrst) begin
               int_sel <= `AOBC_INT_IDLE;
               twos <= 1'b0;
               size_code <= 3'h0;
               ext_sel <= 1'b0;
               clk_en <= 1'b0;
               rate <= `AOBC_RATE_DEF;
            end else begin
               if (wr_ctrl) begin
                  int_sel <= reg_wdata[`AOBC_CTRL_INT_HI:
                                       `AOBC_CTRL_INT_LO];
                  twos <= reg_wdata[`AOBC_CTRL_TWOS];
                  size_code <= reg_wdata[`AOBC_CTRL_SIZE_HI:
                                         `AOBC_CTRL_SIZE_LO];
               end
               // both fields land together from one write
               if (wr_bops) begin
                  ext_sel <= reg_wdata[`AOBC_BOPS_EXT];
                  clk_en <= reg_wdata[`AOBC_BOPS_EN];
               end
               if (wr_rate) begin
                  rate <= reg_wdata[23:0];
               end
            end
         end

         // ----------------------------------------------------------
         // sample clock: internal generator or external edge
         // ----------------------------------------------------------
         aobc_rategen u_rate (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .run(clk_en & ~ext_sel),
            .rate(rate),
            .tick(int_tick)
         );

         // external input is taken as synchronous, one stage is enough
         always @(posedge clk_sys) begin
            if (!nrst) begin
               ext_prev <= 1'b0;
            end else begin
               ext_prev <= ext_all[c];
            end
         end

         assign ext_edge = ext_all[c] & ~ext_prev;
         assign tick = clk_en & (ext_sel ? ext_edge : int_tick);

         // ----------------------------------------------------------
         // buffer; a flush on D06 empties it, and the same write also loads D04 and D05
         // ----------------------------------------------------------
         assign cap = aobc_cap(size_code);
         assign pop = tick & ~empty;

         aobc_fifo u_buf (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .clr(wr_bops & reg_wdata[`AOBC_BOPS_CLR]),
            .wr_en(wr_data),
            .wr_data(reg_wdata[15:0]),
            .rd_en(pop),
            .cap(cap),
            .rd_data(head),
            .level(level),
            .empty(empty),
            .full(full)
         );

         // converter register holds the last value while starved
         always @(posedge clk_sys) begin
            if (!nrst) begin
               dac <= 16'h0000;
               load <= 1'b0;
            end else begin
               load <= pop;
               if (pop) begin
                  dac <= aobc_code(head, twos);
               end
            end
         end

         // ----------------------------------------------------------
         // local request: edge of the selected condition
         // ----------------------------------------------------------
         assign low_q = (level < {2'b00, cap[8:2]});

         always @* begin
            cond = 1'b0;
            if (int_sel == `AOBC_INT_EMPTY) begin
               cond = empty;
            end else if (int_sel == `AOBC_INT_LOQ) begin
               cond = low_q;
            end
         end

         // a change of selection is not itself an edge
         assign raise = cond & ~cond_prev & (sel_prev == int_sel);
         // set wins over a clear in the same cycle
         assign next_flag = raise |
                            (flag & ~(wr_ctrl &
                                      ~reg_wdata[`AOBC_CTRL_FLAG]));

         always @(posedge clk_sys) begin
            if (!nrst) begin
               flag <= 1'b0;
               cond_prev <= 1'b0;
               sel_prev <= `AOBC_INT_IDLE;
            end else begin
               flag <= next_flag;
               cond_prev <= cond;
               sel_prev <= int_sel;
            end
         end

         // ----------------------------------------------------------
         // readback words and outputs
         // ----------------------------------------------------------
         assign ctrl_rb[c*32 +: 32] = {20'h00000, flag, int_sel, 3'h0,
                                       twos, size_code, 1'b0};
         assign bops_rb[c*32 +: 32] = {7'h00, level, 1'b0, full, low_q,
                                       empty, 6'h00, clk_en, ext_sel,
                                       4'h0};
         assign rate_rb[c*32 +: 32] = {8'h00, rate};
         assign dac_all[c*16 +: 16] = dac;
         assign load_all[c] = load;
         assign flag_all[c] = flag;
      end
   endgenerate

   // ----------------------------------------------------------------
   // register read, data one cycle after the strobe and only then
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (!nrst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd && bus_ok) begin
         if (reg_addr[1:0] == `AOBC_OFS_CTRL) begin
            reg_rdata <= reg_addr[2] ? ctrl_rb[63:32] : ctrl_rb[31:0];
         end else if (reg_addr[1:0] == `AOBC_OFS_BOPS) begin
            reg_rdata <= reg_addr[2] ? bops_rb[63:32] : bops_rb[31:0];
         end else if (reg_addr[1:0] == `AOBC_OFS_RATE) begin
            reg_rdata <= reg_addr[2] ? rate_rb[63:32] : rate_rb[31:0];
         end else begin
            reg_rdata <= {16'h0000,
                          reg_addr[2] ? dac_all[31:16] : dac_all[15:0]};
         end
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign dac_data_a = dac_all[15:0];
   assign dac_data_b = dac_all[31:16];
   assign dac_load_a = load_all[0];
   assign dac_load_b = load_all[1];
   assign irq_req = |flag_all; // both channels share one request line

endmodule // aobc_top

`default_nettype wire

// File: aobc_top_properties.sv
// port-level checks for the two-channel output buffer block
`timescale 1ns/1ns
`default_nettype none
module aobc_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic ext_clk_a,
   input wire logic ext_clk_b,
   input wire logic [15:0] dac_data_a,
   input wire logic [15:0] dac_data_b,
   input wire logic dac_load_a,
   input wire logic dac_load_b,
   input wire logic irq_req
);
   logic ena;
   logic exta;
   logic extb;
   // shadow of the clock bits, updated on the same edge as the block
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ena <= 1'b0;
         exta <= 1'b0;
         extb <= 1'b0;
      end else if (reg_wr && reg_addr == 4'h1) begin
         ena <= reg_wdata[5];
         exta <= reg_wdata[4];
      end else if (reg_wr && reg_addr == 4'h5) begin
         extb <= reg_wdata[4];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ----------------------------------------------------------------
   // sequences and properties
   // ----------------------------------------------------------------
   sequence s_ext_rise;
      !$past(ext_clk_b, 2) && $past(ext_clk_b);
   endsequence
   sequence s_flag_keep;
      irq_req && !(reg_wr && reg_addr == 4'h0 && !reg_wdata[11]);
   endsequence
   // reset must win even while disabled elsewhere
   property p_rst_zero;
      disable iff (1'b0) !nrst |=> reg_rdata == 32'h0 && !dac_load_a
         && !dac_load_b && !irq_req && dac_data_a == 16'h0;
   endproperty
   property p_hold_last;
      (!dac_load_a |-> $stable(dac_data_a))
         and (!dac_load_b |-> $stable(dac_data_b));
   endproperty
   property p_gate_off;
      dac_load_a |-> $past(ena);
   endproperty
   property p_ext_src;
      dac_load_b && $past(extb) |-> s_ext_rise;
   endproperty
   property p_ext_pulse;
      dac_load_b && $past(extb) |=> !dac_load_b;
   endproperty
   property p_int_rate;
      dac_load_a && !$past(exta) |=> !dac_load_a [*8];
   endproperty
   property p_flag_hold;
      s_flag_keep |=> irq_req;
   endproperty
   property p_flag_cause;
      $rose(irq_req) |-> $past(dac_load_a || dac_load_b);
   endproperty
   a_rst_zero: assert property (p_rst_zero)
      else $error("outputs not quiet after reset");
   a_hold_last: assert property (p_hold_last)
      else $error("output changed without a load");
   a_gate_off: assert property (p_gate_off)
      else $error("sample left while clock disabled");
   a_ext_src: assert property (p_ext_src)
      else $error("external sample without clock rise");
   a_ext_pulse: assert property (p_ext_pulse)
      else $error("two samples for one external rise");
   a_int_rate: assert property (p_int_rate)
      else $error("internal samples too close");
   a_flag_hold: assert property (p_flag_hold)
      else $error("request dropped without clear");
   a_flag_cause: assert property (p_flag_cause)
      else $error("request raised without a level change");
endmodule // aobc_chk
bind aobc_top aobc_chk u_chk (.clk_sys, .nrst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .ext_clk_a, .ext_clk_b, .dac_data_a,
   .dac_data_b, .dac_load_a, .dac_load_b, .irq_req);
`default_nettype wire

// File: aobc_host.sv
// host model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module aobc_host (
   input wire logic clk_sys,
   input wire logic [31:0] reg_rdata,
   output logic [3:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   // idle bus from time zero
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one-cycle write; the gap cycle keeps strobes from colliding
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // refill block of n words, sized by caller to a quarter..three quarters
   task automatic fill(input int n);
      for (int i = 0; i < n; i++)
         wr(4'h3, 32'(i));
   endtask
endmodule // aobc_host
`default_nettype wire

// File: test_analog_output_buffer_clocking.sv
// self-checking bench for the two-channel output buffer block
`timescale 1ns/1ns
`default_nettype none
module test_analog_output_buffer_clocking;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic ext_clk_a = 1'b0;
   logic ext_clk_b = 1'b0;
   wire [3:0] reg_addr;
   wire [31:0] reg_wdata;
   wire reg_wr;
   wire reg_rd;
   wire [31:0] reg_rdata;
   wire [15:0] dac_data_a;
   wire [15:0] dac_data_b;
   wire dac_load_a;
   wire dac_load_b;
   wire irq_req;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;
   logic [31:0] rv;
   always #50 clk_sys = ~clk_sys;
   aobc_top dut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .ext_clk_a, .ext_clk_b, .dac_data_a, .dac_data_b,
      .dac_load_a, .dac_load_b, .irq_req);
   aobc_host host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task close_out;
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bounded wait for the next channel a sample
   task wait_load(input int lim);
      n = 0;
      do begin
         @(posedge clk_sys);
         #1 n++;
      end while (dac_load_a !== 1'b1 && n < lim);
      chk("dac_load_a", {31'h0, dac_load_a}, 32'h1);
   endtask
   // cut a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      host.rd(4'h0, rv);
      chk("ctrl_a", rv, 32'h0);
      host.rd(4'h1, rv);
      chk("bops_a", rv, 32'h3000);
      host.rd(4'h2, rv);
      chk("rate_a", rv, 32'd300000);
      host.rd(4'h4, rv);
      chk("ctrl_b", rv, 32'h0);
      host.rd(4'hd, rv);
      chk("unmapped", rv, 32'h0);
   endtask
   task t_direct;
      host.wr(4'h3, 32'h1234);
      repeat (40) @(posedge clk_sys);
      #1 chk("held", {16'h0, dac_data_a}, 32'h0);
      host.wr(4'h1, 32'h20);
      wait_load(40);
      chk("first", {16'h0, dac_data_a}, 32'h1234);
      host.wr(4'h3, 32'habcd);
      wait_load(70);
      chk("latency", 32'(n <= 60), 32'h1);
      chk("direct", {16'h0, dac_data_a}, 32'habcd);
   endtask
   // back-to-back writes queue and leave one per tick
   task t_queue;
      for (int k = 0; k < 4; k++)
         host.wr(4'h3, 32'h0100 + k);
      for (int k = 0; k < 4; k++) begin
         wait_load(40);
         chk("order", {16'h0, dac_data_a}, 32'h0100 + k);
         if (k > 0)
            chk("spacing", 32'(n == 33 || n == 34), 32'h1);
      end
      chk("chan_b", {16'h0, dac_data_b}, 32'h0);
   endtask
   task ext_pulse;
      @(posedge clk_sys);
      ext_clk_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ext_clk_b <= 1'b0;
   endtask
   task t_ext;
      host.wr(4'h6, 32'd1000000);
      host.wr(4'h5, 32'h30);
      host.wr(4'h7, 32'h5a5a);
      host.wr(4'h7, 32'ha5a5);
      repeat (50) @(posedge clk_sys);
      #1 chk("ext_idle", {16'h0, dac_data_b}, 32'h0);
      ext_pulse();
      #1 chk("ext_one", {16'h0, dac_data_b}, 32'h5a5a);
      ext_pulse();
      #1 chk("ext_two", {16'h0, dac_data_b}, 32'ha5a5);
   endtask
   // coding, full refusal on a 2 deep size, flush and data readback
   task t_code;
      host.wr(4'h4, 32'h1e);
      for (int k = 1; k < 4; k++)
         host.wr(4'h7, k);
      host.rd(4'h5, rv);
      chk("full_b", rv, 32'h24030);
      ext_pulse();
      #1 chk("twos", {16'h0, dac_data_b}, 32'h8001);
      ext_pulse();
      #1 chk("second", {16'h0, dac_data_b}, 32'h8002);
      ext_pulse();
      #1 chk("refused", {16'h0, dac_data_b}, 32'h8002);
      host.wr(4'h7, 32'h9);
      host.wr(4'h5, 32'h70);
      ext_pulse();
      #1 chk("flushed", {16'h0, dac_data_b}, 32'h8002);
      host.rd(4'h7, rv);
      chk("data_rd", rv, 32'h8002);
   endtask
   // low quarter on a 128 deep active size, then empty
   task t_irq;
      host.wr(4'h1, 32'h0);
      host.fill(40);
      host.wr(4'h0, 32'h302);
      host.wr(4'h1, 32'h20);
      for (int k = 0; k < 8; k++)
         wait_load(40);
      chk("irq_early", {31'h0, irq_req}, 32'h0);
      wait_load(40);
      @(posedge clk_sys);
      #1 chk("irq_loq", {31'h0, irq_req}, 32'h1);
      host.rd(4'h0, rv);
      chk("flag", rv, 32'hb02);
      host.wr(4'h0, 32'h202);
      @(posedge clk_sys);
      #1 chk("irq_clr", {31'h0, irq_req}, 32'h0);
      n = 0;
      while (irq_req !== 1'b1 && n < 1200) begin
         @(posedge clk_sys);
         #1 n++;
      end
      chk("irq_empty", {31'h0, irq_req}, 32'h1);
      host.rd(4'h1, rv);
      chk("empty_bit", {31'h0, rv[12]}, 32'h1);
      host.wr(4'h0, 32'h0);
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_direct();
      t_queue();
      t_ext();
      t_code();
      t_irq();
      close_out();
   end
endmodule // test_analog_output_buffer_clocking
`default_nettype wire
